// >>> core/anp_pkg.sv
// holds constants for the next page transmit word register block
// assumes an ahb-lite master with single whole-word transfers
`default_nettype none
package anp_pkg;
  // the register index is a word index; the bus sees four bytes per word
  localparam logic [31:0] NPTW_INDEX = 32'h0000_0007;
  localparam logic [31:0] NPTW_ADDR = NPTW_INDEX << 2;
  localparam int FURTHER_BIT = 15;
  localparam int RSVD_BIT = 14;
  localparam int MSG_BIT = 13;
  localparam int COMPLY_BIT = 12;
  localparam int TOGGLE_BIT = 11;
  localparam int CODE_HI = 10;
  localparam int WORD_W = 16;
  localparam logic [15:0] NPTW_RESET = 16'h2001;
  localparam logic [15:0] NPTW_WMASK = 16'hb7ff;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage
`default_nettype wire

// >>> core/anp_next_page_tx.sv
// next page transmit word register with ahb-lite slave and arbitration port
// assumes arbitration gives one-cycle request and exchanged-toggle pulses
// assumes this is the one slave, so its hreadyout is the bus hready
`default_nettype none
module anp_next_page_tx (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire logic page_req_in,
  input wire logic exch_valid_in,
  input wire logic exch_toggle_in,
  output logic [15:0] page_word_out,
  output logic page_valid_out
);
  import anp_pkg::*;

  typedef struct packed {
    logic [15:0] word;
    logic wr_pend;
    logic [15:0] tx_word;
    logic tx_valid;
    logic [31:0] rdata;
  } anp_state_t;

  anp_state_t st_r;
  anp_state_t st_nxt;
  logic hit;
  logic hit_wr;
  logic hit_rd;

  ////////////////////////////////////////////////////////////////////////
  // writable bits only; reserved and toggle keep their hardware value
  function automatic logic [15:0] merge_write(input logic [15:0] cur,
    input logic [15:0] wdata);
    logic [15:0] merged;
    merged = (cur & ~NPTW_WMASK) | (wdata & NPTW_WMASK);
    merged[RSVD_BIT] = 1'b0;
    return merged;
  endfunction

  // bus view of the word; the upper half is never backed by storage
  function automatic logic [31:0] bus_view(input logic [15:0] cur);
    logic [31:0] view;
    view = {16'h0000, cur};
    view[RSVD_BIT] = 1'b0;
    return view;
  endfunction

  // only word-sized transfers to the one offset count; others are refused
  function automatic logic addr_hit(input logic sel, input logic rdy,
    input logic [1:0] trans, input logic [31:0] addr,
    input logic [2:0] size);
    logic active;
    active = trans == HTRANS_NONSEQ || trans == HTRANS_SEQ;
    return sel && rdy && active && addr == NPTW_ADDR && size == HSIZE_WORD;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // address phase decode
  always_comb begin
    hit = addr_hit(hsel_in, hready_in, htrans_in, haddr_in, hsize_in);
    hit_wr = hit && hwrite_in;
    hit_rd = hit && !hwrite_in;
  end

  always_comb begin
    st_nxt = st_r;
    // the send strobe lasts exactly one cycle
    st_nxt.tx_valid = 1'b0;
    if (st_r.wr_pend) begin
      st_nxt.word = merge_write(st_r.word, hwdata_in[15:0]);
    end
    if (exch_valid_in) begin
      // hardware wins over a write landing in the same cycle
      st_nxt.word[TOGGLE_BIT] = ~exch_toggle_in;
    end
    st_nxt.word[RSVD_BIT] = 1'b0;
    st_nxt.wr_pend = hit_wr;
    // unmapped or wrong-size reads return zero with an okay response
    st_nxt.rdata = hit_rd ? bus_view(st_nxt.word) : 32'h0000_0000;
    if (page_req_in) begin
      // sends the word as it stands, including a write landing now
      st_nxt.tx_word = st_nxt.word;
      st_nxt.tx_valid = 1'b1;
    end
    if (rst_in) begin
      st_nxt = '0;
      st_nxt.word = NPTW_RESET;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // enable low freezes everything, reset still acts; a write whose data
  // phase falls in a frozen cycle takes hwdata_in of the next enabled cycle, as the slave never stalls
  always_ff @(posedge sys_clk_in) begin
    if (clk_en_in || rst_in) begin
      st_r <= st_nxt;
    end
  end

  // every output is a field of the state register or a constant
  always_comb begin
    hrdata_out = st_r.rdata;
    hreadyout_out = 1'b1;
    hresp_out = 1'b0;
    page_word_out = st_r.tx_word;
    page_valid_out = st_r.tx_valid;
  end

  ////////////////////////////////////////////////////////////////////////
  chk_rsvd_zero: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    st_r.word[RSVD_BIT] == 1'b0)
    else $error("reserved bit set");

  chk_further_wr: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    st_r.wr_pend && clk_en_in |=>
    st_r.word[FURTHER_BIT] == $past(hwdata_in[FURTHER_BIT]))
    else $error("further page write lost");

  chk_msg_wr: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    st_r.wr_pend && clk_en_in |=>
    st_r.word[MSG_BIT] == $past(hwdata_in[MSG_BIT]))
    else $error("message selector write lost");

  chk_comply_wr: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    st_r.wr_pend && clk_en_in |=>
    st_r.word[COMPLY_BIT] == $past(hwdata_in[COMPLY_BIT]))
    else $error("comply write lost");

  chk_code_wr: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    st_r.wr_pend && clk_en_in |=>
    st_r.word[CODE_HI:0] == $past(hwdata_in[CODE_HI:0]))
    else $error("code write lost");

  chk_toggle_inv: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    exch_valid_in && clk_en_in |=>
    st_r.word[TOGGLE_BIT] == !$past(exch_toggle_in))
    else $error("toggle not inverted");

  chk_toggle_hold: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    !exch_valid_in |=> $stable(st_r.word[TOGGLE_BIT]))
    else $error("toggle moved without exchange");

  chk_reset_dflt: assert property (
    @(posedge sys_clk_in)
    rst_in |=> st_r.word == NPTW_RESET && !page_valid_out &&
    hrdata_out == 32'h0000_0000)
    else $error("reset default wrong");

  sequence s_req;
    page_req_in && clk_en_in && !rst_in;
  endsequence
  sequence s_sent;
    page_valid_out && page_word_out == st_r.word;
  endsequence
  chk_page_send: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    s_req |=> s_sent)
    else $error("page word not sent");

  chk_valid_pulse: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    !page_req_in && clk_en_in |=> !page_valid_out)
    else $error("send strobe without request");

  chk_tx_hold: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    !page_req_in |=> $stable(page_word_out))
    else $error("sent word moved without request");

  chk_read_upper: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    hit_rd && clk_en_in |=>
    hrdata_out[31:16] == 16'h0000 && !hrdata_out[RSVD_BIT])
    else $error("read shows bits that must be zero");

  chk_read_word: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    hit_rd && clk_en_in |=> hrdata_out[15:0] == st_r.word)
    else $error("read data differs from the word");

  chk_rdata_idle: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    !hit_rd && clk_en_in |=> hrdata_out == 32'h0000_0000)
    else $error("read data outside a read");

  chk_freeze_state: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    !clk_en_in && !rst_in |=> $stable(st_r))
    else $error("state moved while frozen");

  chk_refuse_write: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    !hit_wr && clk_en_in |=> !st_r.wr_pend)
    else $error("write taken without a hit");

  chk_hold_no_write: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    !st_r.wr_pend && !exch_valid_in && clk_en_in |=> $stable(st_r.word))
    else $error("word moved without write or exchange");

  sequence s_wr_data;
    st_r.wr_pend && clk_en_in && !exch_valid_in;
  endsequence
  chk_wr_toggle_ro: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    s_wr_data |=> $stable(st_r.word[TOGGLE_BIT]))
    else $error("write moved the toggle");
endmodule
`default_nettype wire

// >>> tb/anp_arb_model.sv
// arbitration-side model: turns bench strobes into pulses
// assumes the bench raises req_in or xch_in for one cycle
`default_nettype none
module anp_arb_model (
  input wire logic clk_in,
  input wire logic req_in,
  input wire logic xch_in,
  input wire logic tg_in,
  output logic page_req_out,
  output logic exch_valid_out,
  output logic exch_toggle_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // toggle flips outside exchanges so a stale level is never trusted
  always_ff @(posedge clk_in) begin
    page_req_out <= req_in;
    exch_valid_out <= xch_in;
    exch_toggle_out <= xch_in ? tg_in : ~exch_toggle_out;
  end
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// bench for the next page transmit word register
// assumes zero-wait ahb-lite slave, arbitration model beside it
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import anp_pkg::*;
  logic clk = 1'b0;
  logic rst;
  logic en;
  logic hwrite;
  logic hrdy;
  logic hresp;
  logic req;
  logic xch;
  logic tg;
  logic preq;
  logic pxv;
  logic ptg;
  logic pv;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] r;
  logic [31:0] d;
  logic [15:0] pw;
  logic [15:0] e;
  int fails = 0;
  int cmp_count = 0;

  always #25 clk = ~clk;

  anp_next_page_tx dut (.sys_clk_in(clk), .rst_in(rst), .clk_en_in(en),
    .hsel_in(1'b1), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
    .hready_in(hrdy), .hrdata_out(hrdata), .hreadyout_out(hrdy),
    .hresp_out(hresp), .page_req_in(preq), .exch_valid_in(pxv),
    .exch_toggle_in(ptg), .page_word_out(pw), .page_valid_out(pv));
  anp_arb_model arb (.clk_in(clk), .req_in(req), .xch_in(xch), .tg_in(tg),
    .page_req_out(preq), .exch_valid_out(pxv), .exch_toggle_out(ptg));

  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    cmp_count++;
    if (g !== x) begin
      fails++;
      $display("mismatch t=%0t got %h exp %h", $time, g, x);
    end
  endtask

  task automatic chk_flag(input logic g, input logic x);
    cmp_count++;
    if (g !== x) begin
      fails++;
      $display("mismatch t=%0t flag got %b exp %b", $time, g, x);
    end
  endtask

  task automatic timed_out;
    fails++;
    $display("mismatch t=%0t wait timed out", $time);
    tally_and_finish();
  endtask

  // the bound only guards against a hang; the slave decides the waits
  task automatic wt;
    int n;
    n = 0;
    @(posedge clk);
    while (hrdy !== 1'b1 && n < 64) begin
      @(posedge clk);
      n++;
    end
    if (hrdy !== 1'b1) begin
      timed_out();
    end
  endtask

  task automatic bus(input logic w, input logic [2:0] sz,
    input logic [31:0] a, input logic [31:0] dw);
    @(posedge clk);
    htrans <= HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    hsize <= sz;
    wt();
    htrans <= HTRANS_IDLE;
    hwdata <= dw;
    wt();
    r = hrdata;
    chk_flag(hresp, 1'b0);
  endtask

  task automatic page(input logic [15:0] x);
    int n;
    n = 0;
    @(posedge clk);
    req <= 1'b1;
    @(posedge clk);
    req <= 1'b0;
    @(posedge clk);
    while (pv !== 1'b1 && n < 64) begin
      @(posedge clk);
      n++;
    end
    if (pv !== 1'b1) begin
      timed_out();
    end
    chk({16'h0000, pw}, {16'h0000, x});
    @(posedge clk);
    chk_flag(pv, 1'b0);
  endtask

  // reserved bit reads zero, toggle is the inverse of the exchanged one
  function automatic logic [15:0] ex(input logic [15:0] v, input logic t);
    return {v[15], 1'b0, v[13:12], ~t, v[10:0]};
  endfunction

  initial begin
    rst = 1'b1;
    en = 1'b1;
    hsize = HSIZE_WORD;
    {req, xch, tg, hwrite, htrans, haddr, hwdata} = '0;
    void'($urandom(32'h1181_b77a));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, HSIZE_WORD, NPTW_ADDR, 32'h0000_0000);
    chk(r, 32'h0000_2001);
    bus(1'b1, HSIZE_WORD, NPTW_ADDR, 32'hffff_ffff);
    bus(1'b0, HSIZE_WORD, NPTW_ADDR, 32'h0000_0000);
    chk(r, 32'h0000_b7ff);
    // a byte-sized write is refused and leaves the word alone
    bus(1'b1, 3'h0, NPTW_ADDR, 32'h0000_0000);
    bus(1'b0, HSIZE_WORD, NPTW_ADDR, 32'h0000_0000);
    chk(r, 32'h0000_b7ff);
    bus(1'b0, HSIZE_WORD, 32'h0000_0020, 32'h0000_0000);
    chk(r, 32'h0000_0000);
    repeat (16) begin
      d = $urandom;
      bus(1'b1, HSIZE_WORD, NPTW_ADDR, d);
      @(posedge clk);
      xch <= 1'b1;
      tg <= 1'($urandom);
      @(posedge clk);
      xch <= 1'b0;
      bus(1'b0, HSIZE_WORD, NPTW_ADDR, 32'h0000_0000);
      chk(r, {16'h0000, ex(d[15:0], tg)});
      page(ex(d[15:0], tg));
    end
    // an exchange while the enable is low must not reach the toggle
    e = ex(d[15:0], tg);
    @(posedge clk);
    en <= 1'b0;
    xch <= 1'b1;
    tg <= ~tg;
    @(posedge clk);
    xch <= 1'b0;
    @(posedge clk);
    en <= 1'b1;
    bus(1'b0, HSIZE_WORD, NPTW_ADDR, 32'h0000_0000);
    chk(r, {16'h0000, e});
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, HSIZE_WORD, NPTW_ADDR, 32'h0000_0000);
    chk(r, 32'h0000_2001);
    page(16'h2001);
    tally_and_finish();
  end
endmodule
`default_nettype wire
